// File: rtl/dfw_ctrl.v
// Data flash write controller: control register, half page buffer,
// erase and program sequencing, brown-out handling and interrupt.
// Assumes the core issues one data-pointer store per cycle and that the
// flash array accepts erase and byte program strobes.
`timescale 1ns/1ps
`default_nettype none
`include "dfw_regs.vh"
module dfw_ctrl #(
   parameter ERASE_CYC = `DFW_ERASE_CYC,
   parameter PROG_CYC = `DFW_PROG_CYC,
   parameter BUF_DEPTH = 64,
   parameter PAGE_BYTES = 128,
   parameter FLASH_TOP = 16'h00FF
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [15:0] dp_addr,
   input wire [7:0] dp_wdata,
   input wire dp_store,
   input wire in_app_fuse,
   input wire brownout,
   input wire low_prog_supply,
   output wire data_flash_sel,
   output wire code_signature_space_sel,
   output reg fl_erase,
   output reg fl_prog,
   output reg [15:0] fl_addr,
   output reg [7:0] fl_wdata,
   output reg fl_code_space,
   output wire irq
);
   ////////////////////////////////////////////////////////////////////////
   // Local constants and states.
   localparam AW = 6;
   localparam TW = 24;
   localparam S_IDLE = 2'd0;
   localparam S_ERASE = 2'd1;
   localparam S_PROG = 2'd2;
   localparam S_NEXT = 2'd3;

   // Control bits written by software.
   reg sel_ff;
   reg erase_en_ff;
   reg load_en_ff;
   reg wen_ff;
   reg den_ff;
   // Status held by hardware, and the software interrupt mask.
   reg fault_ff;
   reg [1:0] state_ff;
   reg [7:0] irq_stat_ff;
   reg [7:0] irq_mask_ff;
   // Captured target of the final store.
   reg [15:0] page_base_ff;
   reg code_ff;
   reg [AW:0] idx_ff;
   reg done_pulse_ff;
   reg fault_pulse_ff;
   reg [7:0] nxt_rdata;

   // Returns the half page base of an address.
   function [15:0] half_base;
      input [15:0] a;
      begin
         half_base = {a[15:6], 6'h00};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address routing and write qualification.
   wire code_route = sel_ff && in_app_fuse;
   wire in_flash = den_ff && !code_route && (dp_addr <= FLASH_TOP);
   assign data_flash_sel = in_flash;
   assign code_signature_space_sel = code_route;
   wire inhibit_ok = !low_prog_supply;
   wire busy = (state_ff != S_IDLE);
   wire target_ok = in_flash || code_route;
   wire wr_ok = wen_ff && (den_ff || code_route) && target_ok && inhibit_ok;
   wire st_load = dp_store && wr_ok && !busy;
   wire start = st_load && !load_en_ff && !brownout;

   ////////////////////////////////////////////////////////////////////////
   // Page buffer and phase timer.
   wire buf_clr;
   wire [7:0] buf_rdata;
   wire buf_loaded;
   wire tmr_done;
   reg tmr_load;
   reg [TW-1:0] tmr_val;

   // Buffer takes every qualified store made outside brown-out, including the final one.
   dfw_page_buf #(
      .DEPTH(BUF_DEPTH),
      .AW(AW)
   ) u_buf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .wr_en(st_load && !brownout),
      .wr_addr(dp_addr[AW-1:0]),
      .wr_data(dp_wdata),
      .clr(buf_clr),
      .rd_addr(idx_ff[AW-1:0]),
      .rd_data(buf_rdata),
      .rd_loaded(buf_loaded),
      .any_loaded()
   );

   dfw_timer #(
      .W(TW)
   ) u_tmr (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .value(tmr_val),
      .done(tmr_done)
   );

   // Abort on brown-out while busy; clear the buffer on abort or at the end of the buffer walk.
   wire abort = busy && brownout;
   wire walk_end = (state_ff == S_NEXT) && (idx_ff == BUF_DEPTH);
   assign buf_clr = abort || walk_end;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: optional erase, then one program per loaded byte.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_ff <= S_IDLE;
         page_base_ff <= 16'h0000;
         code_ff <= 1'b0;
         idx_ff <= {(AW+1){1'b0}};
         done_pulse_ff <= 1'b0;
      end
      else
      begin
         done_pulse_ff <= 1'b0;
         if (abort)
         begin
            // Brown-out ends the sequence at once.
            state_ff <= S_IDLE;
         end
         else
         begin
            case (state_ff)
               S_IDLE:
               begin
                  if (start)
                  begin
                     // Final store address selects the half page.
                     page_base_ff <= half_base(dp_addr);
                     code_ff <= code_route;
                     idx_ff <= {(AW+1){1'b0}};
                     state_ff <= erase_en_ff ? S_ERASE : S_NEXT;
                  end
               end
               S_ERASE:
               begin
                  if (tmr_done)
                  begin
                     state_ff <= S_NEXT;
                  end
               end
               S_PROG:
               begin
                  if (tmr_done)
                  begin
                     idx_ff <= idx_ff + {{AW{1'b0}}, 1'b1};
                     state_ff <= S_NEXT;
                  end
               end
               S_NEXT:
               begin
                  if (walk_end)
                  begin
                     state_ff <= S_IDLE;
                     done_pulse_ff <= 1'b1;
                  end
                  else if (buf_loaded)
                  begin
                     state_ff <= S_PROG;
                  end
                  else
                  begin
                     idx_ff <= idx_ff + {{AW{1'b0}}, 1'b1};
                  end
               end
               default:
               begin
                  state_ff <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Timer loads, combinational from the sequencer.
   always @*
   begin
      tmr_load = 1'b0;
      tmr_val = {TW{1'b0}};
      if (state_ff == S_IDLE && start && erase_en_ff && !abort)
      begin
         tmr_load = 1'b1;
         tmr_val = ERASE_CYC[TW-1:0];
      end
      else if (state_ff == S_NEXT && !walk_end && buf_loaded && !abort)
      begin
         tmr_load = 1'b1;
         tmr_val = PROG_CYC[TW-1:0];
      end
   end

   // Flash strobes and data, registered.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fl_erase <= 1'b0;
         fl_prog <= 1'b0;
         fl_addr <= 16'h0000;
         fl_wdata <= 8'h00;
         fl_code_space <= 1'b0;
      end
      else
      begin
         // Erase covers the whole page of the final store.
         fl_erase <= (state_ff == S_IDLE) && start && erase_en_ff && !abort;
         fl_prog <= (state_ff == S_NEXT) && !walk_end && buf_loaded && !abort;
         if (state_ff == S_IDLE && start)
         begin
            fl_addr <= {dp_addr[15:7], 7'h00};
            fl_code_space <= code_route;
         end
         else if (state_ff == S_NEXT && buf_loaded)
         begin
            fl_addr <= page_base_ff | {10'h000, idx_ff[AW-1:0]};
            fl_wdata <= buf_rdata;
            fl_code_space <= code_ff;
         end
      end
   end

   always @(posedge sys_clk)
   begin
      fault_pulse_ff <= !sys_rst && abort;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file, interrupt status and mask.
   wire wr_ctl = reg_wr && (reg_addr == `DFW_OFF_MEMCTL);
   wire wr_stat = reg_wr && (reg_addr == `DFW_OFF_IRQ_STAT);
   wire wr_mask = reg_wr && (reg_addr == `DFW_OFF_IRQ_MASK);
   wire [7:0] ev = {6'h00, fault_pulse_ff, done_pulse_ff};

   // Control bits; fault is set by hardware, cleared by writing zero.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sel_ff <= 1'b0;
         erase_en_ff <= 1'b0;
         load_en_ff <= 1'b0;
         wen_ff <= 1'b0;
         den_ff <= 1'b0;
         fault_ff <= 1'b0;
      end
      else
      begin
         if (wr_ctl)
         begin
            sel_ff <= reg_wdata[`DFW_BIT_SEL];
            erase_en_ff <= reg_wdata[`DFW_BIT_ERASE];
            load_en_ff <= reg_wdata[`DFW_BIT_LOAD];
            wen_ff <= reg_wdata[`DFW_BIT_WEN];
            den_ff <= reg_wdata[`DFW_BIT_DEN];
         end
         if (abort)
         begin
            fault_ff <= 1'b1;
         end
         else if (wr_ctl && !reg_wdata[`DFW_BIT_FAULT])
         begin
            fault_ff <= 1'b0;
         end
      end
   end

   // Sticky events; set wins over write-one-to-clear.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         irq_stat_ff <= 8'h00;
         irq_mask_ff <= 8'h00;
      end
      else
      begin
         irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? reg_wdata : 8'h00)) | ev;
         if (wr_mask)
         begin
            irq_mask_ff <= reg_wdata;
         end
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // Read mux; unmapped addresses read zero.
   always @*
   begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `DFW_OFF_MEMCTL:
         begin
            nxt_rdata = {sel_ff, erase_en_ff, load_en_ff, wen_ff, den_ff,
                         fault_ff, busy, inhibit_ok};
         end
         `DFW_OFF_IRQ_STAT:
         begin
            nxt_rdata = irq_stat_ff;
         end
         `DFW_OFF_IRQ_MASK:
         begin
            nxt_rdata = irq_mask_ff;
         end
         default:
         begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         reg_rdata <= 8'h00;
      end
      else
      begin
         reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
      end
   end
endmodule
`default_nettype wire

// File: rtl/dfw_regs.vh
// Constants for the data flash write controller: register offset, bit
// positions, reset values and timing counts.
// Assumes the includer works at the 20 MHz system clock.
`ifndef DFW_REGS_VH
`define DFW_REGS_VH
`define DFW_OFF_MEMCTL 8'h96
`define DFW_OFF_IRQ_STAT 8'h97
`define DFW_OFF_IRQ_MASK 8'h98
`define DFW_BIT_SEL 7
`define DFW_BIT_ERASE 6
`define DFW_BIT_LOAD 5
`define DFW_BIT_WEN 4
`define DFW_BIT_DEN 3
`define DFW_BIT_FAULT 2
`define DFW_BIT_BUSY 1
`define DFW_BIT_INH 0
`define DFW_MEMCTL_RST 8'h00
`define DFW_ERASE_US 2000
`define DFW_PROG_US 2000
`define DFW_CLK_MHZ 20
`define DFW_ERASE_CYC (`DFW_ERASE_US * `DFW_CLK_MHZ)
`define DFW_PROG_CYC (`DFW_PROG_US * `DFW_CLK_MHZ)
`endif

// File: rtl/dfw_page_buf.v
// Half page buffer with one loaded flag per byte.
// Assumes a synchronous high reset and single writer.
`timescale 1ns/1ps
`default_nettype none
module dfw_page_buf #(
   parameter DEPTH = 64,
   parameter AW = 6
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire clr,
   input wire [AW-1:0] rd_addr,
   output wire [7:0] rd_data,
   output wire rd_loaded,
   output wire any_loaded
);
   // Byte storage.
   reg [7:0] mem [0:DEPTH-1];
   // Loaded flags, one per byte.
   reg [DEPTH-1:0] loaded_ff;

   // A loaded byte blocks later data for that slot; clear empties all.
   always @(posedge sys_clk)
   begin
      if (sys_rst || clr)
      begin
         loaded_ff <= {DEPTH{1'b0}};
      end
      else if (wr_en && !loaded_ff[wr_addr])
      begin
         loaded_ff[wr_addr] <= 1'b1;
      end
   end

   // Data store follows the same block condition.
   always @(posedge sys_clk)
   begin
      if (wr_en && !loaded_ff[wr_addr] && !clr)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem[rd_addr];
   assign rd_loaded = loaded_ff[rd_addr];
   assign any_loaded = |loaded_ff;
endmodule
`default_nettype wire

// File: rtl/dfw_timer.v
// Down counter timing erase and programming phases.
// Assumes load and count come from one controller.
`timescale 1ns/1ps
`default_nettype none
module dfw_timer #(
   parameter W = 20
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire load,
   input wire [W-1:0] value,
   output wire done
);
   // Remaining cycles.
   reg [W-1:0] cnt_ff;

   // Loads, then counts down to zero.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cnt_ff <= {W{1'b0}};
      end
      else if (load)
      begin
         cnt_ff <= value;
      end
      else if (cnt_ff != {W{1'b0}})
      begin
         cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (cnt_ff == {W{1'b0}}) && !load;
endmodule
`default_nettype wire

// File: sim/dfw_ctrl_asserts.sv
// Port checker for the data flash write controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dfw_ctrl_asserts (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [15:0] dp_addr,
   input wire in_app_fuse,
   input wire brownout,
   input wire low_prog_supply,
   input wire data_flash_sel,
   input wire code_signature_space_sel,
   input wire fl_erase,
   input wire fl_prog,
   input wire [15:0] fl_addr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_wok_read: assert property (
      reg_rd && reg_addr == 8'h96 |=> reg_rdata[0] == !$past(low_prog_supply))
      else $error("write-ok bit wrong");
   a_reset_read: assert property (
      $past(sys_rst) && reg_rd && reg_addr == 8'h96 |=> reg_rdata[7:3] == 5'h00)
      else $error("control upper bits not zero after reset");
   a_rd_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_bo_block: assert property (
      brownout [*2] |-> !fl_prog && !fl_erase)
      else $error("flash strobe during brown-out");
   a_code_route: assert property (
      code_signature_space_sel |-> in_app_fuse && !data_flash_sel)
      else $error("code route wrong");
   a_flash_range: assert property (
      data_flash_sel |-> dp_addr <= 16'h00FF)
      else $error("data flash selected out of range");
   a_erase_base: assert property (
      fl_erase |-> fl_addr[6:0] == 7'h00 ##1 !fl_erase)
      else $error("erase not page based pulse");
   a_erase_gap: assert property (
      fl_erase |=> !fl_prog [*4])
      else $error("program too soon after erase");
   a_prog_pulse: assert property (
      fl_prog |=> !fl_prog [*4])
      else $error("program pulses too close");
endmodule
`default_nettype wire

// File: sim/dfw_core_model.sv
// Core model issuing data-pointer stores.
// Assumes the bench calls store() right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dfw_core_model (
   input wire sys_clk,
   output logic [15:0] dp_addr,
   output logic [7:0] dp_wdata,
   output logic dp_store
);
   initial
   begin
      dp_addr = 16'hFFFF;
      dp_wdata = 8'h00;
      dp_store = 1'b0;
   end
   // One store pulse; released lines show the inverse of the last value.
   task automatic store(input logic [15:0] a, input logic [7:0] d, input int gap);
   begin
      dp_store <= 1'b1;
      dp_addr <= a;
      dp_wdata <= d;
      @(posedge sys_clk);
      dp_store <= 1'b0;
      dp_addr <= ~a;
      dp_wdata <= ~d;
      repeat (gap + 1) @(posedge sys_clk);
   end
   endtask
endmodule
`default_nettype wire

// File: sim/test_data_flash_write_control.sv
// Self-checking bench for the data flash write controller.
// Assumes erase and program counts shortened to 5 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_data_flash_write_control;
   logic sys_clk, sys_rst, reg_wr, reg_rd, in_app_fuse, brownout, low_prog_supply, cs, fsel;
   logic [7:0] reg_addr, reg_wdata, v, d;
   logic [15:0] ra;
   wire [7:0] reg_rdata, dp_wdata, fl_wdata;
   wire [15:0] dp_addr, fl_addr;
   wire dp_store, data_flash_sel, code_signature_space_sel, fl_erase, fl_prog, fl_code_space, irq;
   int error_cnt, total_checks;
   logic [24:0] got_q[$];
   logic [15:0] ers_q[$];
   logic [7:0] mdl[int];
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   dfw_ctrl #(.ERASE_CYC(5), .PROG_CYC(5)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .dp_addr(dp_addr), .dp_wdata(dp_wdata), .dp_store(dp_store),
      .in_app_fuse(in_app_fuse), .brownout(brownout), .low_prog_supply(low_prog_supply),
      .data_flash_sel(data_flash_sel), .code_signature_space_sel(code_signature_space_sel), .fl_erase(fl_erase),
      .fl_prog(fl_prog), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
      .fl_code_space(fl_code_space), .irq(irq));
   dfw_core_model i_core (.sys_clk(sys_clk), .dp_addr(dp_addr), .dp_wdata(dp_wdata),
      .dp_store(dp_store));
   // Record every flash strobe, and the data flash select seen by each store.
   always @(posedge sys_clk)
   begin
      if (fl_prog) got_q.push_back({fl_code_space, fl_addr, fl_wdata});
      if (fl_erase) ers_q.push_back(fl_addr);
      if (dp_store) fsel <= data_flash_sel;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
   begin
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= wd;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   end
   endtask
   task automatic rd(input logic [7:0] ad);
   begin
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge sys_clk);
   end
   endtask
   // Poll the busy flag, bounded.
   task automatic wait_idle;
   int n;
   begin
      n = 0;
      rd(8'h96);
      while (v[1] !== 1'b0 && n < 300)
      begin
         rd(8'h96);
         n++;
      end
      chk(v[1], 1'b0);
   end
   endtask
   // Accepted store; the first data loaded into a slot wins.
   task automatic st(input logic [15:0] ad, input logic [7:0] dd);
   begin
      if (!mdl.exists(ad[5:0])) mdl[ad[5:0]] = dd;
      i_core.store(ad, dd, $urandom % 3);
   end
   endtask
   task automatic seq_chk(input logic [15:0] b);
   begin
      foreach (mdl[k])
         chk(got_q.size() ? got_q.pop_front() : 25'h0, {cs, b[15:6], k[5:0], mdl[k]});
      chk(got_q.size(), 0);
      mdl.delete();
   end
   endtask
   task automatic close_out;
   begin
      $display("checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   initial
   begin
      #(30000 * 50);
      error_cnt++;
      close_out;
   end
   initial
   begin
      {reg_wr, reg_rd, in_app_fuse, brownout, low_prog_supply, cs} = 6'h00;
      {reg_addr, reg_wdata} = 16'h0000;
      sys_rst = 1'b1;
      error_cnt = 0;
      total_checks = 0;
      void'($urandom(68333));
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h96);
      chk(v, 8'h01);
      wr(8'h50, 8'hFF);
      rd(8'h50);
      chk(v, 8'h00);
      wr(8'h96, 8'h18);
      rd(8'h96);
      chk(v, 8'h19);
      // Single byte write; its own address picks the half page.
      ra = 16'($urandom % 256);
      st(ra, 8'($urandom));
      wait_idle;
      seq_chk(ra);
      rd(8'h97);
      chk(v, 8'h01);
      chk(irq, 1'b0);
      wr(8'h98, 8'h03);
      chk(irq, 1'b1);
      wr(8'h97, 8'h01);
      chk(irq, 1'b0);
      wr(8'h96, 8'h78);
      st(16'h0085, 8'hA5);
      st(16'h0085, 8'h5A);
      for (int i = 0; i < 10; i++)
         st({10'h002, 6'($urandom % 64)}, 8'($urandom));
      wr(8'h96, 8'h58);
      st(16'h00BF, 8'($urandom));
      wait_idle;
      chk(ers_q.size() ? ers_q.pop_front() : 16'hFFFF, 16'h0080);
      seq_chk(16'h0080);
      wr(8'h96, 8'h18);
      st(16'h00C5, 8'h3C);
      wait_idle;
      chk(ers_q.size(), 0);
      seq_chk(16'h00C5);
      for (int k = 0; k < 4; k++)
      begin
         d = k == 0 ? 8'h08 : (k == 3 ? 8'h10 : 8'h18);
         wr(8'h96, d);
         low_prog_supply <= (k == 1);
         brownout <= (k == 2);
         i_core.store(16'h0010, 8'h00, 0);
         chk(fsel, d[3]);
         rd(8'h96);
         chk(v, d | {7'h00, k != 1});
         low_prog_supply <= 1'b0;
         brownout <= 1'b0;
      end
      wr(8'h97, 8'h03);
      wr(8'h96, 8'h18);
      i_core.store(16'h003F, 8'h00, 2);
      brownout <= 1'b1;
      @(posedge sys_clk);
      brownout <= 1'b0;
      rd(8'h96);
      chk(v, 8'h1D);
      rd(8'h97);
      chk(v, 8'h02);
      chk(got_q.size(), 0);
      wr(8'h96, 8'h1C);
      rd(8'h96);
      chk(v, 8'h1D);
      wr(8'h96, 8'h18);
      rd(8'h96);
      chk(v, 8'h19);
      in_app_fuse <= 1'b1;
      wr(8'h96, 8'h90);
      chk(code_signature_space_sel, 1'b1);
      cs = 1'b1;
      st(16'h1234, 8'h66);
      wait_idle;
      seq_chk(16'h1234);
      close_out;
   end
endmodule
bind dfw_ctrl dfw_ctrl_asserts i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dp_addr(dp_addr),
   .in_app_fuse(in_app_fuse), .brownout(brownout), .low_prog_supply(low_prog_supply),
   .data_flash_sel(data_flash_sel), .code_signature_space_sel(code_signature_space_sel), .fl_erase(fl_erase),
   .fl_prog(fl_prog), .fl_addr(fl_addr));
`default_nettype wire
